// File: logic/bit_invert_exec.sv
// Decode and execute unit for the single word bit toggle instruction
`timescale 1ns/1ps

// Summary of operation
// RQ1 - Invert the one selected bit of the addressed byte and write back.
// RQ2 - Recognise the toggle by opcode 0111 with bit index, access bit, address.
// RQ3 - Status flags untouched; status changes only if it is the operand.
// RQ4 - Access bit 0 uses the access bank; 1 uses the bank select register.
// RQ5 - Extended set, access bit 0, address up to 5Fh: indexed literal offset.
// RQ6 - One program word, completes in one instruction cycle, no stall.
// RQ7 - Phases: decode, read register, compute toggled value, write register.
// RQ8 - Opcode 15:12, bit index 11:9, access bit 8, file address 7:0.
module bit_invert_exec
    import bit_invert_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Instruction and core state
    input  wire logic [15:0] instr_word,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic        ext_set_en,
    input  wire logic [11:0] index_base,
    // Data memory port
    input  wire logic [7:0]  mem_rdata,
    output mem_req_t         mem_req,
    // Status
    output phase_t           phase,
    output logic             exec_hit,
    output logic             status_write
);

    // Addressing modes an operand address can come from
    typedef enum logic [1:0] {
        MODE_BANKED  = 2'b00,
        MODE_INDEXED = 2'b01,
        MODE_ACC_HI  = 2'b11,
        MODE_ACC_LO  = 2'b10
    } addr_mode_t;

    // Fields of the word on the instruction bus
    instr_t      fields;
    logic        is_toggle;

    // Address candidates and the chosen one
    addr_mode_t  next_mode;
    logic [11:0] banked_addr;
    logic [11:0] indexed_addr;
    logic [11:0] acc_hi_addr;
    logic [11:0] acc_lo_addr;
    logic [11:0] next_addr;

    // Toggle arithmetic
    logic [7:0]  bit_mask;
    logic [7:0]  next_result;

    // State of the instruction in flight
    logic        active;
    logic [11:0] addr;
    logic [7:0]  operand;
    logic [7:0]  result;

    // Field split of the fetched word
    assign fields.opcode    = instr_word[OPC_MSB:OPC_LSB];    // [RQ8]
    assign fields.bit_idx   = instr_word[BIT_MSB:BIT_LSB];    // [RQ8]
    assign fields.acc_sel   = instr_word[ACC_POS];            // [RQ8]
    assign fields.file_addr = instr_word[FILE_MSB:FILE_LSB];  // [RQ8]

    // Opcode match; every other opcode leaves memory alone
    assign is_toggle = (fields.opcode == BIT_INVERT_OP);      // [RQ2]

    // Banked form: bank register on top of the file address
    assign banked_addr = {bank_select_reg, fields.file_addr}; // [RQ4]

    // Indexed form wraps at 12 bits, like the data space itself
    assign indexed_addr = 12'(index_base + {4'h0, fields.file_addr}); // [RQ5]

    // Access bank halves: low file registers and high special ones
    assign acc_hi_addr = {ACC_HI_BANK, fields.file_addr};     // [RQ4]
    assign acc_lo_addr = {ACC_LO_BANK, fields.file_addr};     // [RQ4]

    // Mode pick; indexed mode only exists with access bit clear
    always_comb begin
        if (fields.acc_sel) begin
            next_mode = MODE_BANKED;                           // [RQ4]
        end else if (ext_set_en && fields.file_addr <= ILO_LIMIT) begin
            next_mode = MODE_INDEXED;                          // [RQ5]
        end else if (fields.file_addr >= ACC_HI_BASE) begin
            next_mode = MODE_ACC_HI;                           // [RQ4]
        end else begin
            next_mode = MODE_ACC_LO;                           // [RQ4]
        end
    end

    // Effective address from the chosen mode
    always_comb begin
        case (next_mode)
            MODE_BANKED: begin
                next_addr = banked_addr;
            end
            MODE_INDEXED: begin
                next_addr = indexed_addr;
            end
            MODE_ACC_HI: begin
                next_addr = acc_hi_addr;
            end
            MODE_ACC_LO: begin
                next_addr = acc_lo_addr;
            end
            default: begin
                next_addr = acc_lo_addr;
            end
        endcase
    end

    // One hot mask of the selected bit
    always_comb begin
        bit_mask = 8'h00;
        bit_mask[fields.bit_idx] = 1'b1;                       // [RQ1]
    end

    // Only the selected bit flips; the rest pass through untouched
    assign next_result = operand ^ bit_mask;                   // [RQ1]

    // Free running quarter phase; never stalls for this instruction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= PH_DECODE;
        end else begin
            case (phase)
                PH_DECODE: begin
                    phase <= PH_READ;                          // [RQ7]
                end
                PH_READ: begin
                    phase <= PH_PROCESS;                       // [RQ7]
                end
                PH_PROCESS: begin
                    phase <= PH_WRITE;                         // [RQ7]
                end
                PH_WRITE: begin
                    // Back to decode: one cycle per instruction
                    phase <= PH_DECODE;                        // [RQ6]
                end
                default: begin
                    phase <= PH_DECODE;
                end
            endcase
        end
    end

    // Decode verdict, taken once per instruction cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active <= 1'b0;
        end else if (phase == PH_DECODE) begin
            active <= is_toggle;                               // [RQ2]
        end
    end

    // Operand address, frozen so a bus change cannot move the write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= ADDR_RST;
        end else if (phase == PH_DECODE) begin
            addr <= next_addr;                                 // [RQ4]
        end
    end

    // Operand capture in the read phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            operand <= DATA_RST;
        end else if (phase == PH_READ) begin
            operand <= mem_rdata;                              // [RQ7]
        end
    end

    // Toggled byte in the process phase; bit index read from the bus,
    // so the word must still stand here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= DATA_RST;
        end else if (phase == PH_PROCESS) begin
            result <= next_result;                             // [RQ1]
        end
    end

    // Read strobe in the read phase only
    assign mem_req.rd = active && (phase == PH_READ);          // [RQ7]

    // Write strobe in the last phase, whole byte written back
    assign mem_req.wr = active && (phase == PH_WRITE);         // [RQ1]

    // Address and data straight from flops
    assign mem_req.addr  = addr;
    assign mem_req.wdata = result;

    // Instruction in flight is a toggle
    assign exec_hit = active;

    // No flag logic here; status moves only via the normal write path
    assign status_write = 1'b0;                                // [RQ3]

endmodule : bit_invert_exec

// File: logic/bit_invert_pkg.sv
// Package with encodings, field layout and phase states of the bit toggle unit
package bit_invert_pkg;

    // Instruction field layout
    localparam int          OPC_MSB      = 15;
    localparam int          OPC_LSB      = 12;
    localparam int          BIT_MSB      = 11;
    localparam int          BIT_LSB      = 9;
    localparam int          ACC_POS      = 8;
    localparam int          FILE_MSB     = 7;
    localparam int          FILE_LSB     = 0;
    localparam logic [3:0]  BIT_INVERT_OP = 4'h7;

    // Addressing constants
    localparam logic [7:0]  ILO_LIMIT    = 8'h5f;
    localparam logic [7:0]  ACC_HI_BASE  = 8'h60;
    localparam logic [3:0]  ACC_HI_BANK  = 4'hf;
    localparam logic [3:0]  ACC_LO_BANK  = 4'h0;

    // Reset values
    localparam logic [11:0] ADDR_RST     = 12'h000;
    localparam logic [7:0]  DATA_RST     = 8'h00;

    // Quarter phases, Gray ordered
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE   = 2'b10
    } phase_t;

    // Decoded instruction fields
    typedef struct packed {
        logic [3:0] opcode;
        logic [2:0] bit_idx;
        logic       acc_sel;
        logic [7:0] file_addr;
    } instr_t;

    // Data memory access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

endpackage : bit_invert_pkg

// File: test/bit_invert_props.sv
// Checker for the bit toggle unit
`timescale 1ns/1ps
module bit_invert_props
    import bit_invert_pkg::*;
(
    // Clock, reset and inputs
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [15:0] instr_word,
    input wire logic [3:0]  bank_select_reg,
    input wire logic        ext_set_en,
    input wire logic [11:0] index_base,
    input wire logic [7:0]  mem_rdata,
    // Outputs
    input wire mem_req_t    mem_req,
    input wire phase_t      phase,
    input wire logic        exec_hit,
    input wire logic        status_write
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Operand address and indexed mode select
    wire [7:0] f   = instr_word[7:0];
    wire       ilo = ext_set_en && !instr_word[8] && (f <= ILO_LIMIT);
    property p_rd; mem_req.rd |-> phase == PH_READ && exec_hit; endproperty
    a_rd: assert property (p_rd) else $error("read out of phase");
    property p_seq; mem_req.rd |-> ##2 mem_req.wr; endproperty
    a_seq: assert property (p_seq) else $error("write late");
    property p_wd; mem_req.wr |-> mem_req.wdata ==
        ($past(mem_rdata, 2) ^ (8'h01 << instr_word[11:9])); endproperty
    a_wd: assert property (p_wd) else $error("bad toggle");
    property p_wa; mem_req.wr |-> mem_req.addr == $past(mem_req.addr, 2);
    endproperty
    a_wa: assert property (p_wa) else $error("write addr moved");
    property p_op; phase == PH_READ |->
        exec_hit == (instr_word[15:12] == BIT_INVERT_OP); endproperty
    a_op: assert property (p_op) else $error("bad decode");
    property p_bsr; mem_req.rd && instr_word[8] |->
        mem_req.addr == {bank_select_reg, f}; endproperty
    a_bsr: assert property (p_bsr) else $error("bad banked addr");
    property p_acc; mem_req.rd && !instr_word[8] && !ilo |-> mem_req.addr ==
        {(f < ACC_HI_BASE) ? ACC_LO_BANK : ACC_HI_BANK, f}; endproperty
    a_acc: assert property (p_acc) else $error("bad access addr");
    property p_ilo; mem_req.rd && ilo |->
        mem_req.addr == index_base + {4'h0, f}; endproperty
    a_ilo: assert property (p_ilo) else $error("bad indexed addr");
    property p_st; status_write == 1'b0; endproperty
    a_st: assert property (p_st) else $error("status written");
    c_ilo: cover property (mem_req.rd && ilo);
    c_bsr: cover property (mem_req.rd && instr_word[8]);
    c_miss: cover property (phase == PH_READ && !exec_hit);
endmodule : bit_invert_props

bind bit_invert_exec bit_invert_props props (.clk, .rst_b, .instr_word,
    .bank_select_reg, .ext_set_en, .index_base, .mem_rdata, .mem_req,
    .phase, .exec_hit, .status_write);

// File: test/testbench.sv
// Self-checking bench for the bit toggle unit
`timescale 1ns/1ps
module testbench
    import bit_invert_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0]  bank_select_reg = 4'h0;
    logic        ext_set_en = 1'b0;
    logic [11:0] index_base = 12'hff0;
    logic [7:0]  mem_rdata;
    mem_req_t    mem_req;
    phase_t      phase;
    logic        exec_hit;
    logic        status_write;
    logic [7:0]  mem [4096];
    int          fail_count = 0;
    int          compares = 0;
    always #2.5 clk = ~clk;
    // Memory answers at once and stores on the write edge
    assign mem_rdata = mem[mem_req.addr];
    always @(posedge clk) if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    bit_invert_exec dut (.clk, .rst_b, .instr_word, .bank_select_reg,
        .ext_set_en, .index_base, .mem_rdata, .mem_req, .phase, .exec_hit,
        .status_write);
    // Start at decode, hold the word for the whole cycle, then judge the byte
    task automatic run(input logic [15:0] w, input logic [3:0] b,
        input logic e, input logic [11:0] a, input logic [7:0] ini, exp);
        do @(negedge clk); while (phase !== PH_WRITE);
        mem[a] = ini;
        @(posedge clk);
        instr_word <= w;
        bank_select_reg <= b;
        ext_set_en <= e;
        @(posedge clk);
        @(negedge clk);
        compares++;
        if (exec_hit !== (w[15:12] == BIT_INVERT_OP)) begin
            fail_count++;
            $display("Error exec_hit expected %b seen %b",
                w[15:12] == BIT_INVERT_OP, exec_hit);
        end
        compares++;
        if (mem_req.rd !== (w[15:12] == BIT_INVERT_OP)) begin
            fail_count++;
            $display("Error rd expected %b seen %b",
                w[15:12] == BIT_INVERT_OP, mem_req.rd);
        end
        compares++;
        if (status_write !== 1'b0) begin
            fail_count++;
            $display("Error status_write expected 0 seen %b", status_write);
        end
        repeat (3) @(posedge clk);
        instr_word <= 16'h0000; // Idle word so nothing repeats
        @(negedge clk);
        compares++;
        if (mem[a] !== exp) begin
            fail_count++;
            $display("Error mem[%h] expected %h seen %h", a, exp, mem[a]);
        end
    endtask : run
    task automatic final_report();
        $display("Compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // Watchdog, far beyond the roughly 85 cycles the tests need
    initial begin
        #5000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        run(16'h7f20, 4'h3, 1'b0, 12'h320, 8'h75, 8'hf5);
        run(16'h7880, 4'h3, 1'b0, 12'hf80, 8'h75, 8'h65);
        run(16'h705f, 4'h3, 1'b0, 12'h05f, 8'h00, 8'h01);
        run(16'h745f, 4'h3, 1'b1, 12'h04f, 8'hff, 8'hfb);
        run(16'h7660, 4'h3, 1'b1, 12'hf60, 8'h00, 8'h08);
        run(16'h7d10, 4'h2, 1'b1, 12'h210, 8'h00, 8'h40);
        run(16'h6f20, 4'h3, 1'b0, 12'h320, 8'hf5, 8'hf5);
        run(16'h7f20, 4'h3, 1'b0, 12'h320, 8'hf5, 8'h75);
        final_report();
    end
endmodule : testbench
